//--- rtl/spc_pkg.sv
// Shared constants for the four strobe pulse channels.
// Register bits are numbered with bit 0 as the most significant bit of the
// 32-bit word, so document bit n lives at vector index 31-n.
package spc_pkg;

	// Number of identical strobe channels.
	localparam int unsigned NUM_CH = 4;

	// Width of the register byte offset seen on the register port.
	localparam int unsigned ADDR_W = 12;

	// Width of the register data word.
	localparam int unsigned DATA_W = 32;

	// Byte offset of channel 0 control; the others follow at this stride.
	localparam logic [11:0] OFS_CH0 = 12'h200;
	localparam logic [11:0] OFS_CH1 = 12'h204;
	localparam logic [11:0] OFS_CH2 = 12'h208;
	localparam logic [11:0] OFS_CH3 = 12'h20C;

	// Vector index of each field (MSB-first numbering turned around).
	localparam int unsigned PRESENCE_BIT = 31;
	localparam int unsigned ENABLE_BIT   = 25;
	localparam int unsigned POLARITY_BIT = 24;
	localparam int unsigned DELAY_LSB    = 12;
	localparam int unsigned DUR_LSB      = 0;

	// Width of the delay and duration counts.
	localparam int unsigned CNT_W = 12;

	// Reset values of the writable fields.
	localparam logic              ENABLE_RST   = 1'b0;
	localparam logic              POLARITY_RST = 1'b1;
	localparam logic [CNT_W-1:0]  DELAY_RST    = 12'h000;
	localparam logic [CNT_W-1:0]  DUR_RST      = 12'hFFF;

	// Fixed read value of the presence flag.
	localparam logic PRESENCE_VAL = 1'b1;

	// Timing: default unit is one millisecond divided by 1024.
	localparam longint unsigned MS_FS         = 64'd1000000000000;
	localparam longint unsigned TB_DIV        = 64'd1024;
	localparam longint unsigned TIME_BASE_FS  = MS_FS / TB_DIV;
	localparam longint unsigned CLK_PERIOD_FS = 64'd8000000;

	// Width of the per-channel time-base prescaler.
	localparam int unsigned TB_W = 16;

	// Clock cycles in one default time-base unit, rounded down.
	localparam logic [TB_W-1:0] TB_CYCLES = TB_W'(TIME_BASE_FS / CLK_PERIOD_FS);

	// Channel sequencer states.
	typedef enum logic [1:0] {
		SPC_IDLE  = 2'b00,
		SPC_DELAY = 2'b01,
		SPC_PULSE = 2'b10
	} spc_state_t;

endpackage : spc_pkg

//--- rtl/spc_strobe_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module spc_strobe_ctrl
	import spc_pkg::*;
(
	input  wire logic                    ref_clk,        // Camera core clock, 125 MHz.
	input  wire logic                    reset_n,        // Asynchronous reset, active low.
	input  wire logic                    reg_wr,         // Register write strobe.
	input  wire logic                    reg_rd,         // Register read strobe.
	input  wire logic [spc_pkg::ADDR_W-1:0] reg_addr,    // Byte offset from strobe base.
	input  wire logic [spc_pkg::DATA_W-1:0] reg_wdata,   // Write data.
	output var  logic [spc_pkg::DATA_W-1:0] reg_rdata,   // Read data.
	output var  logic                    reg_rvalid,     // Read data valid pulse.
	input  wire logic                    exp_start,      // Exposure start pulse.
	input  wire logic [spc_pkg::TB_W-1:0] tb_cycles_set, // Time-base override, 0 = default.
	input  wire logic [spc_pkg::NUM_CH-1:0] port_is_strobe, // Output port set for strobe.
	output var  logic [spc_pkg::NUM_CH-1:0] strobe_level, // Level for each strobe pin.
	output var  logic [spc_pkg::NUM_CH-1:0] strobe_drive, // Pin carries the strobe.
	output var  logic [spc_pkg::NUM_CH-1:0] strobe_busy   // Channel is in a sequence.
);

	import spc_pkg::*;

	// Stored writable fields, one entry per channel.
	logic                 enable_q   [NUM_CH];   // Channel on.
	logic                 polarity_q [NUM_CH];   // One means active high.
	logic [CNT_W-1:0]     delay_q    [NUM_CH];   // Delay in time-base units.
	logic [CNT_W-1:0]     dur_q      [NUM_CH];   // Duration in time-base units.

	// Sequencer state, one entry per channel.
	spc_state_t           state_q    [NUM_CH];   // Current phase.
	logic [CNT_W-1:0]     units_q    [NUM_CH];   // Units left in the phase.
	logic [TB_W-1:0]      pre_q      [NUM_CH];   // Cycles left in the unit.

	// Decoded register access.
	logic                 hit;                   // Address names a control register.
	logic [1:0]           hit_ch;                // Channel the address names.

	// Cycles per time-base unit in effect.
	logic [TB_W-1:0]      unit_cycles;

	// Packs a channel's fields into the register word, MSB-first layout.
	function automatic logic [DATA_W-1:0] pack_word(
		input logic             en,
		input logic             pol,
		input logic [CNT_W-1:0] dly,
		input logic [CNT_W-1:0] dur
	);
		logic [DATA_W-1:0] w;
		w = '0;
		w[PRESENCE_BIT] = PRESENCE_VAL;
		w[ENABLE_BIT] = en;
		w[POLARITY_BIT] = pol;
		w[DELAY_LSB +: CNT_W] = dly;
		w[DUR_LSB +: CNT_W] = dur;
		return w;
	endfunction : pack_word

	// Decides whether an address is one of the four control words.
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		return (a == OFS_CH0) || (a == OFS_CH1) ||
			(a == OFS_CH2) || (a == OFS_CH3);
	endfunction : addr_hit

	// Address decode: all four words share one layout, so the channel is
	// simply the word index above the channel 0 offset.
	always_comb
	begin
		hit = addr_hit(reg_addr);
		hit_ch = reg_addr[3:2];
	end

	// A zero override keeps the default unit; this keeps a cleared setting
	// from stalling every channel forever.
	always_comb
	begin
		// Limitation: a new override only takes hold at the next unit boundary.
		if (tb_cycles_set != '0)
		begin
			unit_cycles = tb_cycles_set;
		end
		else
		begin
			unit_cycles = TB_CYCLES;
		end
	end

	// Register writes. The enable bit is always writable; the other fields
	// take a write only while the stored enable is already set, so the
	// write that turns a channel on cannot also change its timing.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				enable_q[i] <= ENABLE_RST;
				polarity_q[i] <= POLARITY_RST;
				delay_q[i] <= DELAY_RST;
				dur_q[i] <= DUR_RST;
			end
		end
		else if (reg_wr && hit)
		begin
			enable_q[hit_ch] <= reg_wdata[ENABLE_BIT];
			if (enable_q[hit_ch])
			begin
				// Fields open for writing only on an enabled channel.
				polarity_q[hit_ch] <= reg_wdata[POLARITY_BIT];
				delay_q[hit_ch] <= reg_wdata[DELAY_LSB +: CNT_W];
				dur_q[hit_ch] <= reg_wdata[DUR_LSB +: CNT_W];
			end
			else
			begin
				// Disabled channel: the other fields stay as they are.
				// The same write still lands in the enable bit above.
				polarity_q[hit_ch] <= polarity_q[hit_ch];
				delay_q[hit_ch] <= delay_q[hit_ch];
				dur_q[hit_ch] <= dur_q[hit_ch];
			end
		end
	end

	// Register reads answer one cycle after the strobe. Unmapped offsets
	// read as zero so software probing the space sees no stray bits.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			// Every read strobe is answered, mapped or not.
			reg_rvalid <= reg_rd;
			if (reg_rd && hit)
			begin
				reg_rdata <= pack_word(enable_q[hit_ch], polarity_q[hit_ch],
					delay_q[hit_ch], dur_q[hit_ch]);
			end
			else if (reg_rd)
			begin
				// Unmapped offset.
				reg_rdata <= '0;
			end
		end
	end

	// Per-channel sequencer. The prescaler restarts at each exposure start,
	// so a delay of d units lasts exactly d units with no phase jitter.
	// A new exposure start during a running sequence is ignored; retriggering
	// would cut the light short in the middle of an exposure.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				state_q[i] <= SPC_IDLE;
				units_q[i] <= '0;
				pre_q[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				if (!enable_q[i])
				begin
					// Turning a channel off ends any sequence at once.
					state_q[i] <= SPC_IDLE;
					units_q[i] <= '0;
					pre_q[i] <= '0;
				end
				else
				begin
					unique case (state_q[i])
						SPC_IDLE:
						begin
							pre_q[i] <= unit_cycles - 1'b1;
							// The prescaler stays loaded so the first unit is full.
							// A zero delay with a zero duration starts nothing.
							if (exp_start && delay_q[i] != '0)
							begin
								// Start counting the delay.
								state_q[i] <= SPC_DELAY;
								units_q[i] <= delay_q[i];
							end
							else if (exp_start && dur_q[i] != '0)
							begin
								// Zero delay: go straight to the pulse.
								state_q[i] <= SPC_PULSE;
								units_q[i] <= dur_q[i];
							end
						end
						SPC_DELAY:
						begin
							// Count cycles within a unit, then units within the phase.
							if (pre_q[i] != '0)
							begin
								pre_q[i] <= pre_q[i] - 1'b1;
							end
							else
							begin
								pre_q[i] <= unit_cycles - 1'b1;
								if (units_q[i] != CNT_W'(1))
								begin
									units_q[i] <= units_q[i] - 1'b1;
								end
								else if (dur_q[i] != '0)
								begin
									// Delay over: assert the strobe.
									state_q[i] <= SPC_PULSE;
									units_q[i] <= dur_q[i];
								end
								else
								begin
									// Zero duration: no pulse at all.
									state_q[i] <= SPC_IDLE;
									units_q[i] <= '0;
								end
							end
						end
						SPC_PULSE:
						begin
							if (pre_q[i] != '0)
							begin
								pre_q[i] <= pre_q[i] - 1'b1;
							end
							else
							begin
								pre_q[i] <= unit_cycles - 1'b1;
								if (units_q[i] != CNT_W'(1))
								begin
									units_q[i] <= units_q[i] - 1'b1;
								end
								else
								begin
									// Duration over: back to inactive.
									// The pin stage sees idle one cycle later.
									state_q[i] <= SPC_IDLE;
									units_q[i] <= '0;
								end
							end
						end
						default:
						begin
							// Unused code; recover to idle.
							state_q[i] <= SPC_IDLE;
							units_q[i] <= '0;
						end
					endcase
				end
			end
		end
	end

	// Pin stage. The level follows the sequencer one cycle later, so the
	// active time on the pin equals the pulse phase exactly. The drive flag
	// hands the pin to the strobe only when the port is set for strobe and
	// the channel is on; otherwise the port logic keeps its own source.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			strobe_level <= '0;
			strobe_drive <= '0;
			strobe_busy <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				if (state_q[i] == SPC_PULSE)
				begin
					strobe_level[i] <= polarity_q[i];
				end
				else
				begin
					strobe_level[i] <= ~polarity_q[i];
				end
				// The drive flag follows the enable between sequences too, so
				// the port logic sees a steady owner for the pin.
				strobe_drive[i] <= port_is_strobe[i] & enable_q[i];
				// Busy covers both the delay phase and the pulse phase.
				strobe_busy[i] <= (state_q[i] != SPC_IDLE);
			end
		end
	end

endmodule : spc_strobe_ctrl

`default_nettype wire

//--- verification/spc_strobe_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level watcher for the strobe block; it only observes.
module spc_strobe_ctrl_monitor
	import spc_pkg::*;
(
	input wire logic                         ref_clk,
	input wire logic                         reset_n,
	input wire logic                         reg_wr,
	input wire logic                         reg_rd,
	input wire logic [spc_pkg::ADDR_W-1:0]   reg_addr,
	input wire logic [spc_pkg::DATA_W-1:0]   reg_rdata,
	input wire logic                         reg_rvalid,
	input wire logic                         exp_start,
	input wire logic [spc_pkg::NUM_CH-1:0]   port_is_strobe,
	input wire logic [spc_pkg::NUM_CH-1:0]   strobe_level,
	input wire logic [spc_pkg::NUM_CH-1:0]   strobe_drive,
	input wire logic [spc_pkg::NUM_CH-1:0]   strobe_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("answer without read");
	a_presence_flag: assert property (reg_rvalid && $past(reg_addr[11:4]) == 8'h20
		&& $past(reg_addr[1:0]) == 2'h0 |-> reg_rdata[31]) else $error("presence low");
	a_reserved_zero: assert property (reg_rvalid |-> reg_rdata[30:26] == 5'h00)
		else $error("reserved bits set");
	a_unmapped_zero: assert property (reg_rvalid && $past(reg_addr) == 12'h000
		|-> reg_rdata == 32'h0) else $error("unmapped read not zero");
	a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved");
	a_drive_gated: assert property ((strobe_drive & ~$past(port_is_strobe)) == 4'h0)
		else $error("pin driven while port not strobe");
	a_busy_cause: assert property ((strobe_busy & ~$past(strobe_busy)) != 4'h0
		|-> $past(exp_start, 2)) else $error("sequence began unprompted");
	a_level_quiet: assert property ($changed(strobe_level[0]) && !$past(reg_wr)
		&& !$past(reg_wr, 2) && !$past(reg_wr, 3)
		|-> $past(strobe_busy[0]) || $past(strobe_busy[0], 2))
		else $error("level moved outside sequence");
endmodule : spc_strobe_ctrl_monitor
bind spc_strobe_ctrl spc_strobe_ctrl_monitor u_mon (.ref_clk(ref_clk), .reset_n(reset_n),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .exp_start(exp_start), .port_is_strobe(port_is_strobe),
	.strobe_level(strobe_level), .strobe_drive(strobe_drive), .strobe_busy(strobe_busy));
`default_nettype wire

//--- verification/spc_lamp_model.sv
`timescale 1ns/10ps
`default_nettype none
// Strobe lamp on one output port; counts edges at which it is lit.
module spc_lamp_model
(
	input  wire logic ref_clk,
	input  wire logic pin_drive,
	input  wire logic pin_level,
	input  wire logic act_hi,
	output var  int   lit
);
	// The lamp driver biases its input to the off level, so a released pin
	// stays dark whatever the polarity; only the pin itself is looked at.
	wire logic pin = pin_drive ? pin_level : ~act_hi;
	// The lamp lights on every edge at which its input is at the active level.
	initial
	begin
		lit = 0;
		forever
		begin
			@(posedge ref_clk);
			if (pin === act_hi)
			begin
				lit++;
			end
		end
	end
endmodule : spc_lamp_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import spc_pkg::*;
	localparam int U = 2; // Shortened time-base unit in cycles.
	logic              ref_clk, reset_n, reg_wr, reg_rd, exp_start, reg_rvalid, act_hi;
	logic [11:0]       reg_addr;
	logic [31:0]       reg_wdata, reg_rdata, d;
	logic [3:0]        port_is_strobe, strobe_level, strobe_drive, strobe_busy;
	int                lit, n_errors, num_checks, k, n;
	spc_strobe_ctrl u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .exp_start(exp_start), .tb_cycles_set(16'h0002),
		.port_is_strobe(port_is_strobe), .strobe_level(strobe_level),
		.strobe_drive(strobe_drive), .strobe_busy(strobe_busy));
	spc_lamp_model u_lamp (.ref_clk(ref_clk), .pin_drive(strobe_drive[0]),
		.pin_level(strobe_level[0]), .act_hi(act_hi), .lit(lit));
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge ref_clk) reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk) reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk) reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk) reg_rd <= 1'b0;
		#1;
		chk({31'h0, reg_rvalid}, 32'h1, "rvalid");
		d = reg_rdata;
	endtask : rd
	// Trigger one exposure; k is edges to active level, n lit edges.
	task automatic fire(input logic act);
		int l0;
		int j;
		l0 = lit;
		j = 0;
		k = 0;
		@(posedge ref_clk) exp_start <= 1'b1;
		@(posedge ref_clk) exp_start <= 1'b0;
		while (k < 9000 && strobe_level[0] !== act)
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		chk({31'h0, strobe_busy[0]}, 32'h1, "busy in pulse");
		while (j < 9000 && strobe_busy[0] !== 1'b0)
		begin
			@(posedge ref_clk);
			#1;
			j++;
		end
		chk({31'h0, strobe_busy[0]}, 32'h0, "busy end");
		n = lit - l0;
	endtask : fire
	task automatic t_reset_values;
		for (int i = 0; i < 4; i++)
		begin
			rd(12'h200 + 12'(4 * i));
			chk(d, 32'h8100_0FFF, "reset word");
		end
		rd(12'h000);
		chk(d, 32'h0, "unmapped");
	endtask : t_reset_values
	// Fields stay locked until the channel is on.
	task automatic t_locked;
		wr(12'h204, 32'h00AB_C123);
		rd(12'h204);
		chk(d, 32'h8100_0FFF, "locked");
		wr(12'h204, 32'h02AB_C123);
		rd(12'h204);
		chk(d, 32'h8300_0FFF, "enable only");
		wr(12'h204, 32'h02FF_FFFF);
		rd(12'h204);
		chk(d, 32'h82FF_FFFF, "max counts");
		wr(12'h204, 32'h0000_0000);
	endtask : t_locked
	task automatic t_pulse;
		wr(12'h200, 32'h0200_0000);
		wr(12'h200, 32'h0300_3005);
		rd(12'h200);
		chk(d, 32'h8300_3005, "ch0 word");
		chk({31'h0, strobe_level[0]}, 32'h0, "idle high pol");
		fire(1'b1);
		chk(k, 1 + 3 * U, "delay");
		chk(n, 5 * U, "duration");
		wr(12'h200, 32'h0200_1002);
		act_hi <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk({31'h0, strobe_level[0]}, 32'h1, "idle low pol");
		fire(1'b0);
		chk(k, 1 + U, "delay low");
		chk(n, 2 * U, "duration low");
	endtask : t_pulse
	task automatic t_port_off;
		@(posedge ref_clk) port_is_strobe <= 4'h0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk({31'h0, strobe_drive[0]}, 32'h0, "drive off");
		fire(1'b0);
		chk(n, 0, "lamp dark");
	endtask : t_port_off
	// Reset in mid-run puts the fields and the idle pin level back.
	task automatic t_mid_reset;
		@(posedge ref_clk) reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(12'h200);
		chk(d, 32'h8100_0FFF, "word after reset");
		chk({31'h0, strobe_level[0]}, 32'h0, "level after reset");
	endtask : t_mid_reset
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		{reset_n, reg_wr, reg_rd, exp_start, reg_addr, reg_wdata} = '0;
		port_is_strobe = 4'h1;
		act_hi = 1'b1;
		n_errors = 0;
		num_checks = 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset_values();
		t_locked();
		t_pulse();
		t_port_off();
		t_mid_reset();
		tally_and_finish();
	end
	// Whole run needs about a hundred cycles; cut a hang short.
	initial
	begin
		#100000;
		n_errors++;
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
